// ---- riq_interp.sv ----
// Purpose: Request queue reader, command executor, indication queue writer
// Assumes: Shared memory answers each mem_req with one mem_ack pulse
// Notes:   All control inputs come from logic on ref_clk
//
// How it works
// R1 - Buffer header six bytes, data to 243
// R2 - Oversize request answered with no resource
// R3 - User writes length into buffer headers
// R4 - Request entry: code plus four values
// R5 - User strobes once per added entry
// R6 - Request queue at segment, length n*5
// R7 - Device owns request read offset
// R8 - User owns request write offset
// R9 - Equal offsets empty, one entry spare
// R10 - User advances and wraps write offset
// R11 - 10h starts link, 11h stops it
// R12 - 12h loads ready time from value1
// R13 - 15h starts leave-master action
// R14 - 20h resets, enables, disables watchdog
// R15 - Stop done gives 81h indication
// R16 - Confirm only after offline reached
// R17 - Watchdog expiry gives 84h indication
// R18 - Indication three bytes, raises entry interrupt
// R19 - Full queue drops entry, raises full
// R20 - User sizes indication queue generously
// R21 - Indication queue at segment, length n*3
// R22 - Device owns write, user read offset
// R23 - Address is segment times 32 plus offset
// R24 - Strobe drains pending entries in order
`timescale 1ns/10ps
module riq_interp #(
    parameter int WDOG_CYCLES = riq_pkg::WDOG_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Request queue setup and user pointer
    input  wire logic [7:0]  request_queue_base,
    input  wire logic [7:0]  request_queue_length,
    input  wire logic [7:0]  request_write_offset,
    input  wire logic        request_write_strobe,
    output logic [7:0]       request_read_offset,
    // Indication queue setup and user pointer
    input  wire logic [7:0]  indication_queue_base,
    input  wire logic [7:0]  indication_queue_length,
    input  wire logic [7:0]  indication_read_offset,
    output logic [7:0]       indication_write_offset,
    output logic             indication_entry_irq,
    output logic             indication_full_irq,
    // Shared memory port
    output logic             mem_req,
    output logic             mem_we,
    output logic [12:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    // Link layer control
    output logic             link_start_cmd,
    output logic             link_stop_cmd,
    input  wire logic        link_offline,
    output logic [7:0]       ready_time,
    output logic             ready_time_update_cmd,
    output logic             leave_master_cmd,
    output logic             user_watchdog_on,
    // Received request length check
    input  wire logic        rx_check,
    input  wire logic [7:0]  rx_net_length,
    input  wire logic [7:0]  rx_buffer_length,
    output logic             rx_no_resource
);
    // =========================================================
    // Elaboration check
    if (WDOG_CYCLES < 2) begin : g_bad
        $error("WDOG_CYCLES too small");
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // =========================================================
    // Helpers
    // R23 segment plus offset
    function automatic logic [12:0] phys_addr(input logic [7:0] seg,
                                              input logic [8:0] off);
        return {seg, 5'b0_0000} + {4'h0, off};
    endfunction : phys_addr

    // Advance an offset by one entry, wrapping at the queue end
    function automatic logic [7:0] step_off(input logic [7:0] off,
                                            input logic [7:0] len,
                                            input logic [7:0] size);
        logic [8:0] s;
        s = {1'b0, off} + {1'b0, size};
        return (s >= {1'b0, len}) ? riq_pkg::OFFSET_RST : s[7:0];
    endfunction : step_off

    // =========================================================
    // State
    riq_pkg::riq_state_e state;             // Interpreter state
    logic [7:0]          req_byte [5];      // Fetched request entry
    logic [2:0]          idx;               // Byte within entry
    logic                kick;              // Strobe seen, drain queue
    logic                stop_pend;         // Stop confirmation due
    logic                wd_pend;           // Expiry indication due
    riq_pkg::riq_ind_s   ind_ent;           // Indication being written
    logic                wd_cmd;            // Watchdog command pulse
    logic                wd_expired;        // Watchdog expiry pulse
    riq_pkg::riq_req_s   req_ent;           // Entry as fields

    localparam logic [7:0] REQ_SZ = 8'(riq_pkg::REQ_ENTRY_BYTES);
    localparam logic [7:0] IND_SZ = 8'(riq_pkg::IND_ENTRY_BYTES);

    // =========================================================
    // Decoding
    // R4 entry field layout
    assign req_ent = {req_byte[0], req_byte[1], req_byte[2], req_byte[3], req_byte[4]};
    // R9 empty when equal
    wire       req_empty  = request_read_offset == request_write_offset;
    // R6 wrap at n*5 length
    wire [7:0] req_next   = step_off(request_read_offset, request_queue_length, REQ_SZ);
    // R21 wrap at n*3 length
    wire [7:0] ind_next   = step_off(indication_write_offset, indication_queue_length,
                                     IND_SZ);
    // R22 one entry spare
    wire       ind_full   = ind_next == indication_read_offset;
    wire       ind_due    = stop_pend || wd_pend;
    wire [7:0] ind_code   = stop_pend ? riq_pkg::IND_STOP_CONF : riq_pkg::IND_WD_EXPIRED;
    wire [7:0] ind_byte   = (idx == 3'd0) ? ind_ent.code :
                            (idx == 3'd1) ? ind_ent.v1 : ind_ent.v2;
    wire [12:0] rd_addr   = phys_addr(request_queue_base,
                                      {1'b0, request_read_offset} + 9'(idx));
    wire [12:0] wr_addr   = phys_addr(indication_queue_base,
                                      {1'b0, indication_write_offset} + 9'(idx));
    wire       in_rd      = state == riq_pkg::RIQ_READ;
    wire       in_wr      = state == riq_pkg::RIQ_WRITE;
    wire       in_exec    = state == riq_pkg::RIQ_EXEC;
    wire       last_rd    = in_rd && mem_ack && mem_req && idx == 3'(REQ_SZ - 8'd1);
    wire       last_wr    = in_wr && mem_ack && mem_req && idx == 3'(IND_SZ - 8'd1);
    wire       drop_ind   = state == riq_pkg::RIQ_IDLE && ind_due && ind_full;
    wire       start_ind  = state == riq_pkg::RIQ_IDLE && ind_due && !ind_full;
    wire       clr_stop   = (last_wr || drop_ind) && stop_pend;
    wire       clr_wd     = (last_wr || drop_ind) && !stop_pend;

    // =========================================================
    // Main state machine
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= riq_pkg::RIQ_IDLE;
        end else begin
            case (state)
                riq_pkg::RIQ_IDLE: begin
                    // Indications first, then requests
                    if (start_ind) begin
                        state <= riq_pkg::RIQ_WRITE;
                    end else if (!ind_due && kick && !req_empty) begin
                        state <= riq_pkg::RIQ_READ;
                    end
                end
                riq_pkg::RIQ_READ: begin
                    if (last_rd) begin
                        state <= riq_pkg::RIQ_EXEC;
                    end
                end
                riq_pkg::RIQ_EXEC: begin
                    // R16 hold until offline
                    if (req_ent.code == riq_pkg::CMD_STOP) begin
                        state <= riq_pkg::RIQ_WAIT_OFF;
                    end else begin
                        state <= riq_pkg::RIQ_IDLE;
                    end
                end
                riq_pkg::RIQ_WAIT_OFF: begin
                    if (link_offline) begin
                        state <= riq_pkg::RIQ_IDLE;
                    end
                end
                riq_pkg::RIQ_WRITE: begin
                    if (last_wr) begin
                        state <= riq_pkg::RIQ_IDLE;
                    end
                end
                default: begin
                    state <= riq_pkg::RIQ_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // Memory access: request held until ack, one gap cycle between bytes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 13'h0000;
            mem_wdata <= 8'h00;
            idx       <= 3'd0;
        end else if ((in_rd || in_wr) && !mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= in_wr;
            mem_addr  <= in_wr ? wr_addr : rd_addr;
            mem_wdata <= in_wr ? ind_byte : 8'h00;
        end else if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            idx     <= (last_rd || last_wr) ? 3'd0 : idx + 3'd1;
        end
    end

    // Fetched request bytes land by index
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 5; i++) begin
                req_byte[i] <= 8'h00;
            end
        end else if (in_rd && mem_req && mem_ack) begin
            req_byte[idx] <= mem_rdata;
        end
    end

    // =========================================================
    // Request read offset and drain flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            request_read_offset <= riq_pkg::OFFSET_RST;
            kick                <= 1'b0;
        end else begin
            // R7 R24 advance past entry
            if (in_exec) begin
                request_read_offset <= req_next;
            end
            // R24 strobe wins over clear
            if (request_write_strobe) begin
                kick <= 1'b1;
            end else if (state == riq_pkg::RIQ_IDLE && !ind_due && req_empty) begin
                kick <= 1'b0;
            end
        end
    end

    // =========================================================
    // Command execution
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link_start_cmd        <= 1'b0;
            link_stop_cmd         <= 1'b0;
            ready_time            <= riq_pkg::READY_TIME_RST;
            ready_time_update_cmd <= 1'b0;
            leave_master_cmd      <= 1'b0;
            wd_cmd                <= 1'b0;
        end else begin
            // R11 start and stop
            link_start_cmd        <= in_exec && req_ent.code == riq_pkg::CMD_START;
            link_stop_cmd         <= in_exec && req_ent.code == riq_pkg::CMD_STOP;
            // R13 leave master
            leave_master_cmd      <= in_exec && req_ent.code == riq_pkg::CMD_LEAVE;
            // R14 watchdog control
            wd_cmd                <= in_exec && req_ent.code == riq_pkg::CMD_WATCHDOG;
            ready_time_update_cmd <= in_exec && req_ent.code == riq_pkg::CMD_READY_TIME;
            // R12 ready time load
            if (in_exec && req_ent.code == riq_pkg::CMD_READY_TIME) begin
                ready_time <= req_ent.v1;
            end
        end
    end

    // User watchdog timer
    riq_user_wdog #(
        .CYCLES (WDOG_CYCLES)
    ) u_wdog (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .cmd_valid (wd_cmd),
        .cmd_op    (req_ent.v1),
        .enabled   (user_watchdog_on),
        .expired   (wd_expired)
    );

    // =========================================================
    // Pending indications, a new event wins over its clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_pend <= 1'b0;
            wd_pend   <= 1'b0;
        end else begin
            // R15 R16 stop confirmation
            stop_pend <= (state == riq_pkg::RIQ_WAIT_OFF && link_offline)
                         || (stop_pend && !clr_stop);
            // R17 expiry indication
            wd_pend   <= wd_expired || (wd_pend && !clr_wd);
        end
    end

    // =========================================================
    // Indication write offset and interrupts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            indication_write_offset <= riq_pkg::OFFSET_RST;
            indication_entry_irq    <= 1'b0;
            indication_full_irq     <= 1'b0;
            ind_ent                 <= '0;
        end else begin
            if (start_ind) begin
                ind_ent <= '{code: ind_code, v1: 8'h00, v2: 8'h00};
            end
            // R18 R22 entry written
            if (last_wr) begin
                indication_write_offset <= ind_next;
            end
            indication_entry_irq <= last_wr;
            // R19 drop when full
            indication_full_irq  <= drop_ind;
        end
    end

    // =========================================================
    // R1 R2 data field length check
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_no_resource <= 1'b0;
        end else begin
            rx_no_resource <= rx_check && (rx_net_length > rx_buffer_length);
        end
    end

    // =========================================================
    // Assertions
    a_rd_step: assert property (  // R24
        $changed(request_read_offset) |->
            request_read_offset == riq_pkg::OFFSET_RST ||
            request_read_offset == $past(request_read_offset) + REQ_SZ)
        else $error("read offset moved by other than one entry");

    a_ind_step: assert property (  // R22
        $changed(indication_write_offset) |->
            indication_write_offset == riq_pkg::OFFSET_RST ||
            indication_write_offset == $past(indication_write_offset) + IND_SZ)
        else $error("write offset moved by other than one entry");

    a_entry_irq: assert property (  // R18
        indication_entry_irq |-> $changed(indication_write_offset) && !indication_full_irq)
        else $error("entry interrupt without queue advance");

    a_full_drop: assert property (  // R19
        drop_ind |=> indication_full_irq && $stable(indication_write_offset) ##1
                     $stable(indication_write_offset))
        else $error("full queue still written");

    a_stop_conf: assert property (  // R16
        $rose(stop_pend) |-> $past(link_offline) && $past(state) == riq_pkg::RIQ_WAIT_OFF)
        else $error("stop confirmed before offline");

    a_stop_code: assert property (  // R15
        in_wr && mem_req && idx == 3'd0 && stop_pend |-> mem_wdata == riq_pkg::IND_STOP_CONF)
        else $error("stop confirmation code wrong");

    a_start_cmd: assert property (  // R11
        in_exec && req_ent.code == riq_pkg::CMD_START |=> link_start_cmd ##1 !link_start_cmd)
        else $error("start not a single pulse");

    a_ready_time: assert property (  // R12
        in_exec && req_ent.code == riq_pkg::CMD_READY_TIME |=> ready_time == $past(req_ent.v1))
        else $error("ready time not loaded");

    a_no_res: assert property (  // R2
        rx_check && rx_net_length > rx_buffer_length |=> rx_no_resource)
        else $error("oversize request not refused");

    a_addr_map: assert property (  // R23
        $rose(mem_req) && !mem_we |-> mem_addr ==
            {request_queue_base, 5'b0_0000} + 13'(request_read_offset) + 13'(idx))
        else $error("request address mismatch");

    c_stop_flow: cover property (link_stop_cmd ##[1:50] indication_entry_irq);
    c_full:      cover property (indication_full_irq);
    c_wrap:      cover property (in_exec && req_next == riq_pkg::OFFSET_RST);
    c_wd:        cover property (wd_expired ##[1:40] indication_entry_irq);

endmodule : riq_interp

// ---- riq_pkg.sv ----
// Purpose: Shared constants and types for the request and indication queues
// Assumes: 100 MHz ref_clk, byte-wide shared memory
// Notes:   All offsets are 8-bit, segments shift left by five
package riq_pkg;

    // =========================================================
    // Addressing
    localparam int SEG_SHIFT       = 5;        // Segment granularity of 32 bytes
    localparam int ADDR_W          = 13;       // Physical shared-memory address
    localparam int REQ_ENTRY_BYTES = 5;        // Code plus four values
    localparam int IND_ENTRY_BYTES = 3;        // Code plus two values

    // =========================================================
    // Protocol buffer header layout
    localparam int HDR_LEN_BYTE    = 1;        // Data-length byte position
    localparam int HDR_BYTES       = 6;        // Header size before data
    localparam int DATA_MAX        = 244;      // Data 0 up to Data 243

    // =========================================================
    // Request command codes
    localparam logic [7:0] CMD_START       = 8'h10;
    localparam logic [7:0] CMD_STOP        = 8'h11;
    localparam logic [7:0] CMD_READY_TIME  = 8'h12;
    localparam logic [7:0] CMD_LEAVE       = 8'h15;
    localparam logic [7:0] CMD_WATCHDOG    = 8'h20;

    // Watchdog operations in the first value byte
    localparam logic [7:0] WD_OP_RESET     = 8'h00;
    localparam logic [7:0] WD_OP_ENABLE    = 8'h01;
    localparam logic [7:0] WD_OP_DISABLE   = 8'h02;

    // Indication codes
    localparam logic [7:0] IND_STOP_CONF   = 8'h81;
    localparam logic [7:0] IND_WD_EXPIRED  = 8'h84;

    // =========================================================
    // Reset values
    localparam logic [7:0] OFFSET_RST      = 8'h00;
    localparam logic [7:0] READY_TIME_RST  = 8'h00;

    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int WDOG_TIME_US    = 10;       // User watchdog period
    localparam int WDOG_CYCLES     = (WDOG_TIME_US * 1000) / CLK_PERIOD_NS;

    // =========================================================
    // Types
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] v1;
        logic [7:0] v2;
        logic [7:0] v3;
        logic [7:0] v4;
    } riq_req_s;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] v1;
        logic [7:0] v2;
    } riq_ind_s;

    typedef enum logic [2:0] {
        RIQ_IDLE,
        RIQ_READ,
        RIQ_EXEC,
        RIQ_WAIT_OFF,
        RIQ_WRITE
    } riq_state_e;

endpackage : riq_pkg

// ---- riq_user_wdog.sv ----
// Purpose: User watchdog timer steered by queued commands
// Assumes: One command pulse at a time from the interpreter
// Notes:   Holds after expiry until reset or enable arrives
`timescale 1ns/10ps
module riq_user_wdog #(
    parameter int CYCLES = riq_pkg::WDOG_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_op,
    output logic            enabled,
    output logic            expired
);
    // =========================================================
    // Elaboration check
    if (CYCLES < 2 || CYCLES > 65535) begin : g_bad
        $error("watchdog period out of range");
    end

    logic [15:0] count;                     // Cycles since last reset
    logic        done;                      // Expiry already reported
    wire         op_reset  = cmd_valid && cmd_op == riq_pkg::WD_OP_RESET;
    wire         op_enable = cmd_valid && cmd_op == riq_pkg::WD_OP_ENABLE;
    wire         op_off    = cmd_valid && cmd_op == riq_pkg::WD_OP_DISABLE;
    wire         at_end    = count == 16'(CYCLES - 1);

    // =========================================================
    // Timer
    // R14 reset enable disable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enabled <= 1'b0;
            count   <= 16'h0000;
            done    <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (op_off) begin
                enabled <= 1'b0;
            end else if (op_enable) begin
                enabled <= 1'b1;
            end
            if (op_reset || op_enable) begin
                count <= 16'h0000;
                done  <= 1'b0;
            end else if (enabled && !done) begin
                // R17 expiry pulse
                if (at_end) begin
                    expired <= 1'b1;
                    done    <= 1'b1;
                end else begin
                    count <= count + 16'h0001;
                end
            end
        end
    end

    // R17 expiry needs enable
    a_wd_expire_en: assert property (@(posedge ref_clk) disable iff (rst)
        expired |-> $past(enabled) && $past(at_end))  // R17
        else $error("watchdog expired while not running");

endmodule : riq_user_wdog

// ---- riq_mem_model.sv ----
// Purpose: Shared memory model standing in for the host side
// Assumes: One access at a time from the interpreter
// Notes:   Answers at once, or after two wait states when slow is set
`timescale 1ns/10ps
module riq_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [12:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic [7:0]       mem_rdata,
    output logic             mem_ack
);
    logic [7:0] mem [0:8191];  // Byte-wide shared memory
    logic [1:0] waits = 2'h0;  // Wait states spent on this access
    initial begin
        foreach (mem[i]) mem[i] = 8'hA5;
    end
    // Outside the ack cycle the read bus carries junk
    assign mem_rdata = mem_ack ? mem[mem_addr] : ~mem[mem_addr];
    // ==========================================
    // byte access, one ack per request
    always @(posedge ref_clk) begin
        mem_ack <= 1'b0;
        if (mem_req && !mem_ack) begin
            waits <= (waits == (slow ? 2'h2 : 2'h0)) ? 2'h0 : waits + 2'h1;
            mem_ack <= (waits == (slow ? 2'h2 : 2'h0));
            if (mem_we && waits == (slow ? 2'h2 : 2'h0)) mem[mem_addr] <= mem_wdata;
        end
    end
endmodule : riq_mem_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the request and indication queues
// Assumes: Memory model answers every access
// Notes:   Watchdog shortened to 40 cycles
`timescale 1ns/10ps
module tb_top;
    localparam int WD = 40;  // Shortened watchdog span
    logic [7:0]  request_queue_base = 8'h10, request_queue_length = 8'h19;
    // queue kept small on purpose to reach overflow
    logic [7:0]  indication_queue_base = 8'h20, indication_queue_length = 8'h09;
    logic [7:0]  request_write_offset = 8'h00, indication_read_offset = 8'h00, v;
    logic [7:0]  rx_net_length = 8'h00, rx_buffer_length = 8'h00;
    logic        ref_clk = 1'b0, rst = 1'b1, request_write_strobe = 1'b0, slow = 1'b0;
    logic        link_offline = 1'b0, rx_check = 1'b0;
    logic [7:0]  request_read_offset, indication_write_offset, mem_wdata, mem_rdata, ready_time;
    logic [12:0] mem_addr;
    logic        indication_entry_irq, indication_full_irq, mem_req, mem_we, mem_ack;
    logic        link_start_cmd, link_stop_cmd, ready_time_update_cmd, leave_master_cmd;
    logic        user_watchdog_on, rx_no_resource;
    logic [15:0] notes [$];  // Expected events, oldest first
    logic [31:0] seed = 32'h0000_4415;
    int          fails = 0, comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    riq_interp #(.WDOG_CYCLES(WD)) DUT (.*);
    riq_mem_model PM (.*);
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic take(input logic [15:0] got);
        check(got, notes.size() > 0 ? notes.pop_front() : 16'hDEAD);
    endtask : take
    task automatic put(input logic [7:0] code, input logic [7:0] v1, input logic [15:0] note);
        @(negedge ref_clk);
        if (note !== 16'h0000) notes.push_back(note);
        PM.mem[{request_queue_base, 5'h00} + request_write_offset] = code;
        PM.mem[{request_queue_base, 5'h00} + request_write_offset + 13'h0001] = v1;
        request_write_offset = (request_write_offset == 8'h14) ? 8'h00 : request_write_offset + 8'h05;
        request_write_strobe = 1'b1;
        @(negedge ref_clk) request_write_strobe = 1'b0;
    endtask : put
    task automatic drain();
        for (int n = 0; n < 400 && request_read_offset !== request_write_offset; n++) @(negedge ref_clk);
        check({8'h00, request_read_offset}, {8'h00, request_write_offset});
        repeat (20) @(negedge ref_clk);
    endtask : drain
    task automatic conclude();
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // Every pulse takes the oldest note, sampled mid-cycle where outputs are settled
    always @(negedge ref_clk) if (!rst) begin
        if (link_start_cmd === 1'b1) take(16'h1000);
        if (link_stop_cmd === 1'b1) take(16'h1100);
        if (ready_time_update_cmd === 1'b1) take({8'h12, ready_time});
        if (leave_master_cmd === 1'b1) take(16'h1500);
        if (indication_entry_irq === 1'b1) take({8'hE0, indication_write_offset});
        if (indication_full_irq === 1'b1) take(16'hF000);
        if (rx_no_resource === 1'b1) take(16'hA000);
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        check({request_read_offset, indication_write_offset}, 16'h0000);
        check({ready_time, 7'h00, user_watchdog_on}, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            slow = i[0];
            v = rnd();
            put(8'h10, 8'h00, 16'h1000);
            put(8'h12, v, {8'h12, v});
            put(8'h15, 8'h00, 16'h1500);
            put(8'h20, 8'h05, 16'h0000);
            drain();
        end
        $display("commands done");
        put(8'h20, 8'h01, 16'hE003);
        drain();
        repeat (WD + 20) @(negedge ref_clk);
        check({15'h0000, user_watchdog_on}, 16'h0001);
        check({PM.mem[13'h0400], PM.mem[13'h0401]}, 16'h8400);
        indication_read_offset = 8'h03;
        put(8'h20, 8'h02, 16'h0000);
        put(8'h20, 8'h00, 16'h0000);
        drain();
        check({15'h0000, user_watchdog_on}, 16'h0000);
        $display("watchdog done");
        put(8'h11, 8'h00, 16'h1100);
        notes.push_back(16'hE006);
        put(8'h10, 8'h00, 16'h1000);
        repeat (60) @(negedge ref_clk);
        check({8'h00, indication_write_offset}, 16'h0003);
        link_offline = 1'b1;
        drain();
        link_offline = 1'b0;
        check({PM.mem[13'h0403], PM.mem[13'h0405]}, 16'h8100);
        $display("stop done");
        indication_read_offset = 8'h00;
        put(8'h20, 8'h01, 16'hF000);
        drain();
        repeat (WD + 20) @(negedge ref_clk);
        check({8'h00, indication_write_offset}, 16'h0006);
        put(8'h20, 8'h02, 16'h0000);
        drain();
        $display("overflow done");
        // user supplies the recorded buffer length
        for (int i = 0; i < 40; i++) begin
            rx_net_length = (i == 0) ? 8'hF4 : rnd();
            rx_buffer_length = (i == 0) ? 8'hF4 : rnd();
            rx_check = 1'b1;
            if (rx_net_length > rx_buffer_length) notes.push_back(16'hA000);
            @(negedge ref_clk) rx_check = 1'b0;
            @(negedge ref_clk);
        end
        repeat (4) @(negedge ref_clk);
        check(notes.size(), 16'h0000);
        $display("length check done");
        conclude();
    end
    initial begin
        #200000;
        fails++;
        conclude();
    end
endmodule : tb_top
